// [hw/tspr_render.sv]
// Purpose: per-pixel background and sprite renderer with palette lookup
// Assumes: beam, request and video data come from logic on clk_sys
// Notes: one pixel per request, roughly 8..87 cycles each
// How it works
// RULE_01 - tile is 16 bytes, two bit planes
// RULE_02 - patterns fetched from 0000h/1000h external regions
// RULE_03 - name table tile indices, ctrl1 bit4 table
// RULE_04 - attribute byte gives quadrant palette
// RULE_05 - four name tables, 3000h range folds down
// RULE_06 - scroll wraps into neighbour table, y negative
// RULE_07 - selected name table number goes outside
// RULE_08 - optional mask of left 8 background pixels
// RULE_09 - 64 sprites, at most 8 per line
// RULE_10 - 256-byte sprite memory, port access only
// RULE_11 - byte 0 is y minus one, byte 3 x
// RULE_12 - 8x8 tile index, ctrl1 bit3 table
// RULE_13 - 8x16 uses even/odd pair, bit0 table
// RULE_14 - attribute flips, priority, palette; bits 4-2 zero
// RULE_15 - lowest numbered opaque sprite only
// RULE_16 - behind sprite hidden by opaque background
// RULE_17 - sprite zero hit sets status bit 6
// RULE_18 - hit cleared at vblank end only
// RULE_19 - 3F00h backdrop, palettes at fixed slots
// RULE_20 - gap slots stored, aliases and repeats
// RULE_21 - luminance and hue, upper bits unstored
// RULE_22 - monochrome clears the hue bits
// RULE_23 - backdrop when layer disabled or clipped
// RULE_24 - pattern value zero is transparent
`timescale 1ns/1ps
`default_nettype none
module tspr_render import tspr_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] beam_x,
  input wire logic [7:0] beam_y,
  input wire logic pix_req,
  input wire logic vblank_end,
  output logic [13:0] vram_addr,
  output logic vram_rd,
  input wire logic [7:0] vram_rdata,
  output logic [1:0] nametable_select,
  output logic [5:0] pix_color,
  output logic pix_valid,
  output logic busy
);
  tspr_state_t state;
  logic [7:0] ctrl1;
  logic [7:0] ctrl2;
  logic [7:0] scroll_x;
  logic [7:0] scroll_y;
  logic [7:0] oam_addr;
  logic [4:0] pal_addr;
  logic hit;
  logic [7:0] sprite_attribute_memory [256];
  logic [7:0] px;
  logic [7:0] py;
  logic [7:0] tile;
  logic [7:0] at_byte;
  logic [7:0] pl;
  logic [7:0] ph;
  logic [5:0] sidx;
  logic [3:0] cnt;
  logic [7:0] sp_lo;
  logic [2:0] sp_col;
  logic [1:0] sp_pal;
  logic [1:0] sp_bits;
  logic sp_behind;
  logic sp_zero;
  logic spr_opq;
  // geometry and lookup terms
  logic [9:0] sy_ext;
  logic [9:0] wy_raw;
  logic [9:0] wy;
  logic nt_y;
  logic [7:0] row;
  logic [8:0] wx;
  logic [13:0] nt_base;
  logic [13:0] nt_addr;
  logic [13:0] at_addr;
  logic [7:0] at_sh;
  logic [1:0] bg_bits;
  logic bg_opq;
  logic [7:0] s_y;
  logic [7:0] s_t;
  logic [7:0] s_a;
  logic [7:0] s_x;
  logic [7:0] dy;
  logic [8:0] dx9;
  logic tall;
  logic s_line;
  logic s_xhit;
  logic [3:0] srow;
  logic [7:0] s_tile;
  logic s_tbl;
  logic [1:0] s_bits;
  logic [4:0] pal_idx;
  logic [5:0] pal_a;
  logic [5:0] pal_b;
  logic hit_set;
  logic pal_wr;

  // 3000h..3EFFh is a second view of the table area
  function automatic logic [13:0] fold_vram(input logic [13:0] a);
    fold_vram = (a >= VA_MIRROR_LO && a <= VA_MIRROR_HI) ? a - VA_MIRROR_OFS : a; // RULE_05
  endfunction

  // region bit, tile, plane-0 row; plane 1 is eight bytes on
  function automatic logic [13:0] pat_addr(input logic tbl, input logic [7:0] t,
                                           input logic [2:0] r);
    pat_addr = {1'b0, tbl, t, 1'b0, r}; // RULE_01 RULE_02
  endfunction

  // background scroll geometry
  always_comb begin
    sy_ext = {2'b00, scroll_y};
    if (scroll_y > SCROLL_Y_MAX) begin
      sy_ext = {2'b00, scroll_y} - Y_NEG_OFS; // RULE_06
    end
    wy_raw = (ctrl1[C1_NT_Y] ? NT_H : 10'h000) + {2'b00, py} + sy_ext;
    wy = wy_raw;
    // positive sums reach 734, so bit 9 alone would misread them as negative
    if (wy_raw >= WORLD_H + WORLD_H) begin
      wy = wy_raw + WORLD_H; // RULE_06
    end else if (wy_raw >= WORLD_H) begin
      wy = wy_raw - WORLD_H; // RULE_06
    end
    nt_y = (wy >= NT_H);
    row = nt_y ? 8'(wy - NT_H) : wy[7:0];
    wx = {ctrl1[C1_NT_X], scroll_x} + {1'b0, px}; // RULE_06
    nt_base = VA_NT_BASE | {2'b00, nt_y, wx[8], 10'h000}; // RULE_05
    nt_addr = fold_vram(nt_base | {4'h0, row[7:3], wx[7:3]}); // RULE_03
    at_addr = fold_vram(nt_base | VA_ATTR_OFS | {8'h00, row[7:5], wx[7:5]}); // RULE_04
    at_sh = at_byte >> {row[4], wx[4], 1'b0}; // RULE_04
    bg_bits = {ph[~wx[2:0]], pl[~wx[2:0]]}; // RULE_01
    bg_opq = ctrl2[C2_BG_EN] && !(ctrl2[C2_BG_CLIP] && px < CLIP_W) // RULE_08 RULE_23
             && bg_bits != 2'b00; // RULE_24
  end

  // current sprite under scan
  always_comb begin
    s_y = sprite_attribute_memory[{sidx, 2'b00}]; // RULE_10
    s_t = sprite_attribute_memory[{sidx, 2'b01}];
    s_a = sprite_attribute_memory[{sidx, 2'b10}];
    s_x = sprite_attribute_memory[{sidx, 2'b11}];
    tall = ctrl1[C1_SPR_TALL];
    dy = py - (s_y + 8'h01); // RULE_11
    s_line = !(s_y >= SPR_Y_HIDE_LO && s_y <= SPR_Y_HIDE_HI) // RULE_11
             && dy < (tall ? SPR_H_TALL : SPR_H_SHORT); // RULE_09
    dx9 = {1'b0, px} - {1'b0, s_x}; // RULE_11
    s_xhit = !dx9[8] && dx9[7:3] == 5'h00;
    srow = dy[3:0] ^ {tall & s_a[7], {3{s_a[7]}}}; // RULE_14
    s_tile = tall ? {s_t[7:1], srow[3]} : s_t; // RULE_12 RULE_13
    s_tbl = tall ? s_t[0] : ctrl1[C1_SPR_TBL]; // RULE_12 RULE_13
    s_bits = {vram_rdata[~sp_col], sp_lo[~sp_col]};
  end

  // layer priority; zero index means backdrop
  always_comb begin
    pal_idx = 5'h00; // RULE_23
    if (spr_opq && !(sp_behind && bg_opq)) begin // RULE_16
      pal_idx = {1'b1, sp_pal, sp_bits}; // RULE_19
    end else if (bg_opq) begin
      pal_idx = {1'b0, at_sh[1:0], bg_bits}; // RULE_19
    end
  end

  // hit ignores the behind-background bit on purpose
  assign hit_set = clk_en && state == S_PAL && spr_opq && sp_zero && bg_opq; // RULE_17
  assign pal_wr = reg_wr && reg_addr == REG_PAL_DATA;

  tspr_palette u_pal (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .wr_en(pal_wr),
    .wr_idx(pal_addr),
    .wr_data(reg_wdata[5:0]),
    .rd_a_idx(pal_idx),
    .rd_a_data(pal_a),
    .rd_b_idx(pal_addr),
    .rd_b_data(pal_b)
  );

  // fetch and scan sequencer; memory data lands one cycle after rd
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      px <= 8'h00;
      py <= 8'h00;
      vram_addr <= 14'h0000;
      vram_rd <= 1'b0;
      nametable_select <= 2'h0;
      tile <= 8'h00;
      at_byte <= 8'h00;
      pl <= 8'h00;
      ph <= 8'h00;
      sidx <= 6'h00;
      cnt <= 4'h0;
      sp_lo <= 8'h00;
      sp_col <= 3'h0;
      sp_pal <= 2'h0;
      sp_bits <= 2'h0;
      sp_behind <= 1'b0;
      sp_zero <= 1'b0;
      spr_opq <= 1'b0;
      busy <= 1'b0;
    end else if (clk_en) begin
      vram_rd <= 1'b0;
      unique case (state)
        S_IDLE: begin
          if (pix_req) begin
            px <= beam_x;
            py <= beam_y;
            busy <= 1'b1;
            state <= S_NT;
          end
        end
        S_NT: begin
          vram_addr <= nt_addr; // RULE_03
          vram_rd <= 1'b1;
          nametable_select <= {nt_y, wx[8]}; // RULE_07
          state <= S_AT;
        end
        S_AT: begin
          tile <= vram_rdata;
          vram_addr <= at_addr; // RULE_04
          vram_rd <= 1'b1;
          state <= S_PL;
        end
        S_PL: begin
          at_byte <= vram_rdata;
          vram_addr <= pat_addr(ctrl1[C1_BG_TBL], tile, row[2:0]); // RULE_03
          vram_rd <= 1'b1;
          state <= S_PH;
        end
        S_PH: begin
          pl <= vram_rdata;
          vram_addr <= vram_addr | VA_PLANE_HI; // RULE_01
          vram_rd <= 1'b1;
          state <= S_BGD;
        end
        S_BGD: begin
          ph <= vram_rdata;
          sidx <= 6'h00;
          cnt <= 4'h0;
          spr_opq <= 1'b0;
          state <= S_SCAN;
        end
        S_SCAN: begin
          // a ninth sprite on the line ends the scan unseen
          if (!ctrl2[C2_SPR_EN] || (s_line && cnt == SPR_LINE_MAX)) begin // RULE_09
            state <= S_PAL;
          end else if (s_line && s_xhit) begin
            cnt <= cnt + 4'h1;
            sp_col <= dx9[2:0] ^ {3{s_a[6]}}; // RULE_14
            sp_pal <= s_a[1:0]; // RULE_14
            sp_behind <= s_a[5]; // RULE_14
            sp_zero <= (sidx == 6'h00);
            vram_addr <= pat_addr(s_tbl, s_tile, srow[2:0]); // RULE_12 RULE_13
            vram_rd <= 1'b1;
            state <= S_SLO;
          end else begin
            if (s_line) begin
              cnt <= cnt + 4'h1;
            end
            if (sidx == SPR_LAST) begin
              state <= S_PAL;
            end else begin
              sidx <= sidx + 6'h01;
            end
          end
        end
        S_SLO: begin
          sp_lo <= vram_rdata;
          vram_addr <= vram_addr | VA_PLANE_HI; // RULE_01
          vram_rd <= 1'b1;
          state <= S_SHI;
        end
        S_SHI: begin
          // first opaque sprite wins, even if it then hides
          if (s_bits != 2'b00) begin // RULE_15 RULE_24
            spr_opq <= 1'b1;
            sp_bits <= s_bits;
            state <= S_PAL;
          end else if (sidx == SPR_LAST) begin
            state <= S_PAL;
          end else begin
            sidx <= sidx + 6'h01;
            state <= S_SCAN;
          end
        end
        S_PAL: begin
          busy <= 1'b0;
          state <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // pixel output, masked for monochrome
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pix_color <= 6'h00;
      pix_valid <= 1'b0;
    end else if (clk_en) begin
      pix_valid <= (state == S_PAL);
      if (state == S_PAL) begin
        pix_color <= pal_a & (ctrl2[C2_MONO] ? MONO_MASK : FULL_MASK); // RULE_21 RULE_22
      end
    end
  end

  // software-written control registers and pointers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl1 <= CTRL_RST;
      ctrl2 <= CTRL_RST;
      scroll_x <= SCROLL_RST;
      scroll_y <= SCROLL_RST;
      oam_addr <= 8'h00;
      pal_addr <= 5'h00;
    end else if (clk_en && reg_wr) begin
      unique case (reg_addr)
        REG_CTRL1: ctrl1 <= reg_wdata;
        REG_CTRL2: ctrl2 <= reg_wdata;
        REG_SCROLL_X: scroll_x <= reg_wdata; // RULE_06
        REG_SCROLL_Y: scroll_y <= reg_wdata; // RULE_06
        REG_OAM_ADDR: oam_addr <= reg_wdata;
        REG_OAM_DATA: oam_addr <= oam_addr + 8'h01;
        REG_PAL_ADDR: pal_addr <= reg_wdata[4:0]; // RULE_20
        REG_PAL_DATA: pal_addr <= pal_addr + 5'h01;
        default: ;
      endcase
    end
  end

  // sprite memory, reachable only through the data port
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 256; i++) begin
        sprite_attribute_memory[i] <= 8'h00;
      end
    end else if (clk_en && reg_wr && reg_addr == REG_OAM_DATA) begin
      sprite_attribute_memory[oam_addr] <= (oam_addr[1:0] == 2'b10) ? // RULE_10
        reg_wdata & OAM_ATTR_MASK : reg_wdata; // RULE_14
    end
  end

  // hit flag: no software path, set beats the clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hit <= 1'b0;
    end else if (hit_set) begin
      hit <= 1'b1; // RULE_17
    end else if (clk_en && vblank_end) begin
      hit <= 1'b0; // RULE_18
    end
  end

  // read data the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        unique case (reg_addr)
          REG_CTRL1: reg_rdata <= ctrl1;
          REG_CTRL2: reg_rdata <= ctrl2;
          REG_STATUS: reg_rdata <= 8'(hit) << ST_HIT; // RULE_17
          REG_OAM_ADDR: reg_rdata <= oam_addr;
          REG_OAM_DATA: reg_rdata <= sprite_attribute_memory[oam_addr]; // RULE_10
          REG_SCROLL_X: reg_rdata <= scroll_x;
          REG_SCROLL_Y: reg_rdata <= scroll_y;
          REG_PAL_ADDR: reg_rdata <= {3'b000, pal_addr};
          REG_PAL_DATA: reg_rdata <= {2'b00, pal_b}; // RULE_21
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_lo_issue;
    clk_en && state == S_PH && vram_rd;
  endsequence
  sequence s_hi_issue;
    vram_rd && vram_addr == ($past(vram_addr) | VA_PLANE_HI);
  endsequence

  a_plane_pair: assert property ( // RULE_01
    s_lo_issue |-> !vram_addr[3] ##1 s_hi_issue)
    else $error("plane 1 fetch not eight bytes after plane 0");
  a_attr_fetch: assert property ( // RULE_04
    state == S_PL && vram_rd |-> vram_addr[13:12] == 2'b10 && vram_addr[9:6] == 4'hF)
    else $error("attribute fetch outside attribute area");
  a_mirror_fold: assert property ( // RULE_05
    vram_rd |-> vram_addr[13:12] != 2'b11)
    else $error("render fetch in mirror range");
  a_ntsel_match: assert property ( // RULE_07
    state == S_AT && vram_rd |-> nametable_select == vram_addr[11:10])
    else $error("name table select disagrees with address");
  a_clip_left: assert property ( // RULE_08
    state == S_PAL && ctrl2[C2_BG_CLIP] && px < CLIP_W |-> !bg_opq)
    else $error("clipped column shows background");
  a_spr_limit: assert property ( // RULE_09
    state == S_SLO |-> cnt != 4'h0 && cnt <= SPR_LINE_MAX)
    else $error("sprite fetched beyond line limit");
  a_oam_zero: assert property ( // RULE_14
    clk_en && reg_rd && reg_addr == REG_OAM_DATA && oam_addr[1:0] == 2'b10
    |=> reg_rdata[4:2] == 3'b000)
    else $error("unused attribute bits read nonzero");
  a_behind_bg: assert property ( // RULE_16
    state == S_PAL && spr_opq && sp_behind && bg_opq |-> !pal_idx[4])
    else $error("behind sprite drawn over background");
  a_hit_cause: assert property ( // RULE_17
    $rose(hit) |-> $past(hit_set))
    else $error("hit set without sprite zero overlap");
  a_hit_clear: assert property ( // RULE_18
    clk_en && vblank_end && !hit_set |=> !hit)
    else $error("hit not cleared at vblank end");
  a_mono_mask: assert property ( // RULE_22
    clk_en && state == S_PAL && ctrl2[C2_MONO] |=> pix_valid && pix_color[3:0] == 4'h0)
    else $error("monochrome pixel keeps hue bits");
  a_backdrop: assert property ( // RULE_23
    state == S_PAL && !spr_opq && !bg_opq |-> pal_idx == 5'h00)
    else $error("empty pixel not backdrop");
endmodule
`default_nettype wire

// [hw/tspr_pkg.sv]
// Purpose: shared constants and state type for the tile/sprite/palette renderer
// Assumes: 14-bit video address space, 8-bit register port
// Notes: register offsets index a plain port, not a public bus
`default_nettype none
package tspr_pkg;
  // register port offsets
  localparam logic [3:0] REG_CTRL1 = 4'h0;
  localparam logic [3:0] REG_CTRL2 = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam logic [3:0] REG_OAM_ADDR = 4'h3;
  localparam logic [3:0] REG_OAM_DATA = 4'h4;
  localparam logic [3:0] REG_SCROLL_X = 4'h5;
  localparam logic [3:0] REG_SCROLL_Y = 4'h6;
  localparam logic [3:0] REG_PAL_ADDR = 4'h7;
  localparam logic [3:0] REG_PAL_DATA = 4'h8;
  // field positions
  localparam int C1_NT_X = 0;
  localparam int C1_NT_Y = 1;
  localparam int C1_SPR_TBL = 3;
  localparam int C1_BG_TBL = 4;
  localparam int C1_SPR_TALL = 5;
  localparam int C2_MONO = 0;
  localparam int C2_BG_CLIP = 1;
  localparam int C2_BG_EN = 3;
  localparam int C2_SPR_EN = 4;
  localparam int ST_HIT = 6;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] SCROLL_RST = 8'h00;
  // video address map
  localparam logic [13:0] VA_NT_BASE = 14'h2000;
  localparam logic [13:0] VA_MIRROR_LO = 14'h3000;
  localparam logic [13:0] VA_MIRROR_HI = 14'h3EFF;
  localparam logic [13:0] VA_MIRROR_OFS = 14'h1000;
  localparam logic [13:0] VA_ATTR_OFS = 14'h03C0;
  localparam logic [13:0] VA_PLANE_HI = 14'h0008;
  // scroll geometry
  localparam logic [7:0] SCROLL_Y_MAX = 8'hEF;
  localparam logic [9:0] NT_H = 10'h0F0;
  localparam logic [9:0] WORLD_H = 10'h1E0;
  localparam logic [9:0] Y_NEG_OFS = 10'h100;
  localparam logic [7:0] CLIP_W = 8'h08;
  // sprites
  localparam logic [7:0] SPR_Y_HIDE_LO = 8'hEF;
  localparam logic [7:0] SPR_Y_HIDE_HI = 8'hFE;
  localparam logic [7:0] SPR_H_SHORT = 8'h08;
  localparam logic [7:0] SPR_H_TALL = 8'h10;
  localparam logic [7:0] OAM_ATTR_MASK = 8'hE3;
  localparam logic [3:0] SPR_LINE_MAX = 4'h8;
  localparam logic [5:0] SPR_LAST = 6'h3F;
  // palette
  localparam logic [5:0] MONO_MASK = 6'h30;
  localparam logic [5:0] FULL_MASK = 6'h3F;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_NT = 4'h1,
    S_AT = 4'h2,
    S_PL = 4'h3,
    S_PH = 4'h4,
    S_BGD = 4'h5,
    S_SCAN = 4'h6,
    S_SLO = 4'h7,
    S_SHI = 4'h8,
    S_PAL = 4'h9
  } tspr_state_t;
endpackage
`default_nettype wire

// [hw/tspr_palette.sv]
// Purpose: 32-slot palette store with backdrop aliasing
// Assumes: index already folded to 5 bits by the caller
// Notes: two combinational read ports, one write port
`timescale 1ns/1ps
`default_nettype none
module tspr_palette import tspr_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic [4:0] wr_idx,
  input wire logic [5:0] wr_data,
  input wire logic [4:0] rd_a_idx,
  output logic [5:0] rd_a_data,
  input wire logic [4:0] rd_b_idx,
  output logic [5:0] rd_b_data
);
  logic [5:0] mem [32];

  // sprite color-0 slots fold onto the background ones
  function automatic logic [4:0] pal_slot(input logic [4:0] i);
    pal_slot = (i[1:0] == 2'b00) ? {1'b0, i[3:0]} : i; // RULE_20
  endfunction

  // six stored bits only; upper bits never reach the array
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 32; i++) begin
        mem[i] <= 6'h00;
      end
    end else if (clk_en && wr_en) begin
      mem[pal_slot(wr_idx)] <= wr_data; // RULE_20
    end
  end

  // slot 0 doubles as the shared backdrop
  assign rd_a_data = mem[pal_slot(rd_a_idx)]; // RULE_19
  assign rd_b_data = mem[pal_slot(rd_b_idx)];
endmodule
`default_nettype wire

// [sim/tspr_cart_model.sv]
// Purpose: cartridge side of the video bus, pattern memory and name table blocks
// Assumes: vertical mirroring, table number bit 0 picks the internal block
// Notes: data is good only while the read strobe is high, inverted otherwise
`timescale 1ns/1ps
`default_nettype none
module tspr_cart_model (
  input wire logic [13:0] vram_addr,
  input wire logic vram_rd,
  input wire logic [1:0] nametable_select,
  output logic [7:0] vram_rdata
);
  logic [7:0] pat [0:8191];
  logic [7:0] blk [0:2047];

  // pattern bytes come from here only, the console has none of its own
  function automatic logic [7:0] fetch(input logic [13:0] a, input logic [1:0] nt);
    if (a < 14'h2000) begin
      return pat[a[12:0]];
    end
    return blk[{nt[0], a[9:0]}];
  endfunction

  // blank memories so unused tiles are transparent
  initial begin
    for (int i = 0; i < 8192; i++) begin
      pat[i] = 8'h00;
    end
    for (int i = 0; i < 2048; i++) begin
      blk[i] = 8'h00;
    end
  end

  // the renderer captures at the edge that ends its read cycle, so answer
  // within that cycle; inverted data outside it catches late sampling
  always_comb begin
    vram_rdata = fetch(vram_addr, nametable_select);
    if (!vram_rd) begin
      vram_rdata = ~vram_rdata;
    end
  end
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// Purpose: self-checking bench for the tile/sprite/palette renderer
// Assumes: cartridge model with vertical mirroring on the far side
// Notes: each scenario task judges its own results but builds on memory, palette and OAM set by earlier tasks
`timescale 1ns/1ps
`default_nettype none
module tb_top import tspr_pkg::*; ;
  logic clk_sys, rst_n, clk_en, reg_wr, reg_rd, pix_req, vblank_end, vram_rd, pix_valid, busy;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, beam_x, beam_y, vram_rdata, r;
  logic [13:0] vram_addr;
  logic [1:0] nametable_select;
  logic [5:0] c, pix_color_w;
  int error_cnt, n_tests;

  tspr_render DUT (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .beam_x(beam_x), .beam_y(beam_y), .pix_req(pix_req), .vblank_end(vblank_end),
    .vram_addr(vram_addr), .vram_rd(vram_rd), .vram_rdata(vram_rdata),
    .nametable_select(nametable_select), .pix_color(pix_color_w), .pix_valid(pix_valid),
    .busy(busy));
  tspr_cart_model cart (.vram_addr(vram_addr), .vram_rd(vram_rd),
    .nametable_select(nametable_select), .vram_rdata(vram_rdata));

  task automatic end_of_test();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one-cycle strobes, released on the following edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    d = reg_rdata;
  endtask

  task automatic pal(input logic [7:0] idx, input logic [7:0] v);
    wr(REG_PAL_ADDR, idx);
    wr(REG_PAL_DATA, v);
  endtask

  // request one pixel, wait bounded for the valid pulse
  task automatic pix(input logic [7:0] x, input logic [7:0] y, output logic [5:0] col);
    int i;
    @(posedge clk_sys);
    beam_x <= x;
    beam_y <= y;
    pix_req <= 1'b1;
    @(posedge clk_sys);
    pix_req <= 1'b0;
    for (i = 0; i < 200; i++) begin
      @(posedge clk_sys);
      if (i == 0) chk({7'h00, busy}, 8'h01);
      if (pix_valid === 1'b1) break;
    end
    if (i == 200) begin
      error_cnt++;
      end_of_test();
    end else begin
      col = pix_color_w;
      chk({7'h00, busy}, 8'h00);
    end
  endtask

  // a write while the enable is low must leave the register alone
  task automatic t_reset();
    clk_en <= 1'b0;
    wr(REG_CTRL1, 8'h10);
    clk_en <= 1'b1;
    rd(REG_CTRL1, r);
    chk(r, CTRL_RST);
    rd(4'h9, r);
    chk(r, 8'h00);
  endtask

  // aliases, repeats and unstored upper bits
  task automatic t_palette();
    pal(8'h10, 8'h0F);
    pal(8'h09, 8'h2A);
    pal(8'h01, 8'h11);
    pal(8'h17, 8'h15);
    pal(8'h1B, 8'h05);
    pal(8'h24, 8'h3C);
    pal(8'h08, 8'hFF);
    wr(REG_PAL_ADDR, 8'h00);
    rd(REG_PAL_DATA, r);
    chk(r, 8'h0F);
    wr(REG_PAL_ADDR, 8'h04);
    rd(REG_PAL_DATA, r);
    chk(r, 8'h3C);
    wr(REG_PAL_ADDR, 8'h08);
    rd(REG_PAL_DATA, r);
    chk(r, 8'h3F);
  endtask

  task automatic t_oam();
    logic [7:0] spr [8];
    spr = '{8'hFF, 8'h02, 8'h1D, 8'h00, 8'hFF, 8'h02, 8'h02, 8'h00};
    wr(REG_OAM_ADDR, 8'h00);
    foreach (spr[i]) wr(REG_OAM_DATA, spr[i]);
    wr(REG_OAM_ADDR, 8'h02);
    rd(REG_OAM_DATA, r);
    chk(r, 8'h01);
  endtask

  // tile 1 row 0 leftmost pixel opaque, attribute palette 2 top-left
  task automatic t_bg();
    cart.pat[13'h0010] = 8'h80;
    cart.pat[13'h0020] = 8'hFF;
    cart.pat[13'h0028] = 8'hFF;
    cart.pat[13'h1020] = 8'hFF;
    cart.pat[13'h1028] = 8'hFF;
    cart.blk[0] = 8'h01;
    cart.blk[1] = 8'h01;
    cart.blk[11'h3C0] = 8'h02;
    cart.blk[11'h400] = 8'h01;
    wr(REG_CTRL2, 8'h08);
    pix(8'd0, 8'd0, c);
    chk({2'b00, c}, 8'h2A);
    pix(8'd1, 8'd0, c);
    chk({2'b00, c}, 8'h0F);
    wr(REG_CTRL1, 8'h10);
    pix(8'd0, 8'd0, c);
    chk({2'b00, c}, 8'h0F);
    wr(REG_CTRL1, 8'h00);
    wr(REG_CTRL2, 8'h09);
    pix(8'd0, 8'd0, c);
    chk({2'b00, c}, 8'h20);
    wr(REG_CTRL2, 8'h0A);
    pix(8'd0, 8'd0, c);
    chk({2'b00, c}, 8'h0F);
    pix(8'd8, 8'd0, c);
    chk({2'b00, c}, 8'h2A);
    wr(REG_CTRL2, 8'h00);
    pix(8'd0, 8'd0, c);
    chk({2'b00, c}, 8'h0F);
  endtask

  // horizontal wrap into the next table, vertical value above 239 negative
  task automatic t_scroll();
    wr(REG_CTRL2, 8'h08);
    wr(REG_SCROLL_X, 8'h08);
    pix(8'd248, 8'd0, c);
    chk({2'b00, c}, 8'h11);
    chk({6'h00, nametable_select}, 8'h01);
    wr(REG_SCROLL_X, 8'h00);
    wr(REG_SCROLL_Y, 8'hF8);
    pix(8'd0, 8'd8, c);
    chk({2'b00, c}, 8'h2A);
    wr(REG_SCROLL_Y, 8'h00);
  endtask

  task automatic t_sprite();
    wr(REG_CTRL2, 8'h18);
    pix(8'd0, 8'd0, c);
    chk({2'b00, c}, 8'h15);
    rd(REG_STATUS, r);
    chk({7'h00, r[ST_HIT]}, 8'h01);
    @(posedge clk_sys);
    vblank_end <= 1'b1;
    @(posedge clk_sys);
    vblank_end <= 1'b0;
    rd(REG_STATUS, r);
    chk({7'h00, r[ST_HIT]}, 8'h00);
    wr(REG_STATUS, 8'h40);
    rd(REG_STATUS, r);
    chk({7'h00, r[ST_HIT]}, 8'h00);
    wr(REG_OAM_ADDR, 8'h02);
    wr(REG_OAM_DATA, 8'h21);
    pix(8'd0, 8'd0, c);
    chk({2'b00, c}, 8'h2A);
    rd(REG_STATUS, r);
    chk({7'h00, r[ST_HIT]}, 8'h01);
    wr(REG_OAM_ADDR, 8'h01);
    wr(REG_OAM_DATA, 8'h03);
    wr(REG_OAM_DATA, 8'h01);
    wr(REG_CTRL1, 8'h20);
    pix(8'd0, 8'd0, c);
    chk({2'b00, c}, 8'h15);
    wr(REG_CTRL1, 8'h00);
    pix(8'd0, 8'd0, c);
    chk({2'b00, c}, 8'h05);
  endtask

  // free-running system clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // main sequence
  initial begin
    error_cnt = 0;
    n_tests = 0;
    rst_n = 1'b0;
    {reg_wr, reg_rd, pix_req, vblank_end} = 4'h0;
    clk_en = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    beam_x = 8'h00;
    beam_y = 8'h00;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_palette();
    t_oam();
    t_bg();
    t_scroll();
    t_sprite();
    end_of_test();
  end
endmodule
`default_nettype wire
